/* File: rtl/emp_pkg.sv */
/*
 * Package for the expanded-memory page mapper: port addresses, field
 * positions, reset values and the structs that carry page entries, control
 * state and mapping results.
 * Assumes a 16-bit I/O data path and a 24-bit processor memory address.
 */
package emp_pkg;
	timeunit 1ns;
	timeprecision 1ns;

	// I/O port addresses of the mapper registers.
	localparam logic [15:0] EMP_PORT_CTRL = 16'h6872;
	localparam logic [15:0] EMP_PORT_INDEX = 16'he072;
	localparam logic [15:0] EMP_PORT_DATA = 16'he872;

	// Index register layout and limits.
	localparam int EMP_INDEX_W = 6;
	localparam logic [5:0] EMP_INDEX_RST = 6'h00;
	localparam logic [5:0] EMP_INDEX_LAST = 6'h27;
	localparam logic [5:0] EMP_INDEX_STEP = 6'h01;
	localparam int EMP_OBSERVE_W = 10;
	localparam int EMP_NUM_PAGES = 40;
	localparam int EMP_NUM_LOWER = 32;
	localparam int EMP_NUM_UPPER = 8;

	// Control register field positions.
	localparam int EMP_CTRL_ADV_BIT = 15;
	localparam int EMP_CTRL_BASE_LSB = 13;
	localparam int EMP_CTRL_MODE_LSB = 10;

	// Page register field positions.
	localparam int EMP_PAGE_EN_BIT = 15;
	localparam int EMP_PAGE_W = 12;
	localparam int EMP_PAGE_EXT_BIT = 11;

	// Window frames, counted in 16 KB units of the processor address.
	localparam int EMP_OFFSET_W = 14;
	localparam logic [5:0] EMP_UPPER_BASE_FRAME = 6'h31;
	localparam logic [5:0] EMP_UPPER_SPAN = 6'h07;
	localparam logic [5:0] EMP_LOWER_FIRST_FRAME = 6'h08;
	localparam logic [5:0] EMP_LOWER_LAST_FRAME = 6'h27;
	localparam logic [5:0] EMP_LOWER_WRAP_FRAME = 6'h20;
	localparam logic [2:0] EMP_UPPER_REG_TOP = 3'h4;
	localparam logic [2:0] EMP_LOWER_WRAP_TOP = 3'h0;

	// Supported page number ranges.
	localparam logic [11:0] EMP_PAGE_ONB_LOW_LAST = 12'h027;
	localparam logic [11:0] EMP_PAGE_ONB_HIGH_FIRST = 12'h040;

	// Mapping enable field encodings.
	typedef enum logic [1:0] {
		EMP_MAP_OFF = 2'b00,
		EMP_MAP_PROG = 2'b01,
		EMP_MAP_UPPER = 2'b10,
		EMP_MAP_ALL = 2'b11
	} emp_map_mode_t;

	// One stored page register; bits 14 to 12 are not stored.
	typedef struct packed {
		logic en;
		logic [11:0] page;
	} emp_page_t;

	localparam emp_page_t EMP_PAGE_RST = '{en: 1'b0, page: 12'h000};

	// Mapper control fields.
	typedef struct packed {
		logic adv;
		logic [1:0] base_sel;
		emp_map_mode_t mode;
	} emp_ctrl_t;

	localparam emp_ctrl_t EMP_CTRL_RST = '{adv: 1'b0, base_sel: 2'b00, mode: EMP_MAP_OFF};

	// Result of one processor access lookup.
	typedef struct packed {
		logic onboard;
		logic ext_cs;
		logic [24:0] addr;
		logic [7:0] ext_page;
	} emp_map_t;

	localparam emp_map_t EMP_MAP_RST = '{onboard: 1'b0, ext_cs: 1'b0, addr: 25'h0000000,
		ext_page: 8'h00};

endpackage

/* File: rtl/emp_page_mem.sv */
/*
 * Storage for the forty page registers, one write port and two read ports
 * whose data come out of registers one cycle after the address.
 * Assumes the caller never writes an index above the last page register.
 */
module emp_page_mem
	import emp_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Write port.
	input wire logic we_i,
	input wire logic [5:0] waddr_i,
	input wire emp_pkg::emp_page_t wdata_i,
	// Read ports.
	input wire logic [5:0] raddr_a_i,
	output emp_pkg::emp_page_t rdata_a_o,
	input wire logic [5:0] raddr_b_i,
	output emp_pkg::emp_page_t rdata_b_o
);
	timeunit 1ns;
	timeprecision 1ns;
	emp_page_t lower_q [EMP_NUM_LOWER];
	emp_page_t upper_q [EMP_NUM_UPPER];
	emp_page_t rd_a_q;
	emp_page_t rd_b_q;

	// Look up one entry; indexes past the last register read as zero.
	function automatic emp_page_t fetch(input logic [5:0] idx, input emp_page_t lo [EMP_NUM_LOWER],
		input emp_page_t up [EMP_NUM_UPPER]);
		emp_page_t r;
		r = EMP_PAGE_RST;
		if (idx > EMP_INDEX_LAST) begin
			r = EMP_PAGE_RST;
		end else if (idx[5]) begin
			r = up[idx[2:0]];
		end else begin
			r = lo[idx[4:0]];
		end
		return r;
	endfunction

	// Lower registers carry no reset, so they power up holding junk.
	always_ff @(posedge clk_i) begin
		if (we_i && !waddr_i[5]) begin
			lower_q[waddr_i[4:0]] <= wdata_i;
		end
	end

	// Upper registers clear on reset so their windows start disabled.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < EMP_NUM_UPPER; i++) begin
				upper_q[i] <= EMP_PAGE_RST;
			end
		end else if (we_i && waddr_i[5]) begin
			upper_q[waddr_i[2:0]] <= wdata_i;
		end
	end

	// Registered reads; a read in the write cycle returns the old value.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_a_q <= EMP_PAGE_RST;
			rd_b_q <= EMP_PAGE_RST;
		end else begin
			rd_a_q <= fetch(raddr_a_i, lower_q, upper_q);
			rd_b_q <= fetch(raddr_b_i, lower_q, upper_q);
		end
	end

	assign rdata_a_o = rd_a_q;
	assign rdata_b_o = rd_b_q;

endmodule

/* File: rtl/emp_mapper.sv */
/*
 * Expanded-memory page mapper: control, index and page data ports on the
 * I/O side, and translation of processor memory accesses in the upper and
 * lower 16 KB windows into on-board addresses or external card cycles.
 * Assumes one-cycle I/O read and write strobes synchronous to clk_i and a
 * one-cycle processor access strobe with a stable address in that cycle.
 * Lower page registers have no reset, so software must load every lower
 * register before it selects mode 11.
 */
module emp_mapper
	import emp_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic arst_n_i,
	// I/O port access.
	input wire logic [15:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [15:0] io_wdata_i,
	output logic [15:0] io_rdata_o,
	output logic io_rvalid_o,
	// Delay-line test observation.
	input wire logic delay_test_trigger_i,
	input wire logic [emp_pkg::EMP_OBSERVE_W-1:0] delay_line_observe_i,
	// Processor memory access.
	input wire logic cpu_valid_i,
	input wire logic [23:0] cpu_addr_i,
	// Translation result.
	output logic map_valid_o,
	output logic map_onboard_o,
	output logic [24:0] map_addr_o,
	output logic ems_cs_o,
	output logic [7:0] shared_peripheral_bus_o,
	output logic shared_peripheral_bus_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import emp_pkg::*;

	// Source of the second read stage. The page store needs a cycle of its
	// own, so the source travels with the pending read instead of the address.
	typedef enum logic [1:0] {
		EMP_RD_INDEX,
		EMP_RD_DATA,
		EMP_RD_CTRL,
		EMP_RD_ZERO
	} emp_rd_src_t;

	// Control and index registers with their next values.
	emp_ctrl_t ctrl_q;
	emp_ctrl_t ctrl_d;
	logic [5:0] index_q;
	logic [5:0] index_d;

	// Read pipeline state.
	logic rd_pend_q;
	emp_rd_src_t rd_src_q;
	logic [15:0] rd_hold_q;
	logic [15:0] io_rdata_q;
	logic io_rvalid_q;

	// Lookup pipeline state.
	logic lk_valid_q;
	logic lk_upper_q;
	logic lk_lower_q;
	logic [EMP_OFFSET_W-1:0] lk_off_q;
	emp_map_t map_q;
	emp_map_t map_d;
	logic map_valid_q;

	// Registered entries from the page store.
	emp_page_t io_entry;
	emp_page_t lk_entry;

	// Page numbers that translate to on-board memory.
	// Pages 40 to 63 fall in neither range and so translate to nothing,
	// which keeps an unsupported page from reaching some random memory.
	function automatic logic page_onboard(input logic [11:0] page);
		return (page <= EMP_PAGE_ONB_LOW_LAST) ||
			((page >= EMP_PAGE_ONB_HIGH_FIRST) && !page[EMP_PAGE_EXT_BIT]);
	endfunction

	// Page numbers that select external card memory.
	// Card pages from 2304 up have one of bits 10 to 8 set and are refused.
	function automatic logic page_external(input logic [11:0] page);
		return page[EMP_PAGE_EXT_BIT] && (page[10:8] == 3'h0);
	endfunction

	// Port decode; programming is refused while mapping is fully off.
	// The control port stays reachable in every mode, or software could
	// never leave mode 00 again.
	wire sel_ctrl = (io_addr_i == EMP_PORT_CTRL);
	wire sel_index = (io_addr_i == EMP_PORT_INDEX);
	wire sel_data = (io_addr_i == EMP_PORT_DATA);
	wire prog_ok = (ctrl_q.mode != EMP_MAP_OFF);
	wire index_wr = io_wr_i && sel_index && prog_ok;
	wire data_acc = (io_rd_i || io_wr_i) && sel_data && prog_ok;
	wire index_ok = (index_q <= EMP_INDEX_LAST);
	wire page_we = io_wr_i && sel_data && prog_ok && index_ok;
	wire ctrl_wr = io_wr_i && sel_ctrl;

	// Write data cut to stored fields; bits 14 to 12 are dropped.
	wire emp_page_t page_wdata = '{en: io_wdata_i[EMP_PAGE_EN_BIT],
		page: io_wdata_i[EMP_PAGE_W-1:0]};

	// Index register next value: a write wins, else data accesses advance while adv is set.
	// The index wraps at 63; values above 39 reach no register, so a data
	// access there reads zero and writes nothing, yet still advances.
	always_comb begin
		index_d = index_q;
		if (index_wr) begin
			index_d = io_wdata_i[EMP_INDEX_W-1:0];
		end else if (data_acc && ctrl_q.adv) begin
			index_d = index_q + EMP_INDEX_STEP;
		end
	end

	// Control fields; bits outside this block's fields are not kept.
	// The unused bits and the lower boundary field belong to other logic,
	// so they read back as zero here.
	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_wr) begin
			ctrl_d.adv = io_wdata_i[EMP_CTRL_ADV_BIT];
			ctrl_d.base_sel = io_wdata_i[EMP_CTRL_BASE_LSB +: 2];
			ctrl_d.mode = emp_map_mode_t'(io_wdata_i[EMP_CTRL_MODE_LSB +: 2]);
		end
	end

	// Register state and reset values.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= EMP_CTRL_RST;
			index_q <= EMP_INDEX_RST;
		end else begin
			ctrl_q <= ctrl_d;
			index_q <= index_d;
		end
	end

	// Values read back from the index and control ports.
	// The observe bits are live inputs, so they are captured in the request
	// cycle like every other read source.
	wire [EMP_OBSERVE_W-1:0] observe_bits = delay_test_trigger_i ?
		delay_line_observe_i : '0;
	wire [15:0] index_rd = {observe_bits, index_q};
	wire [15:0] ctrl_rd = {ctrl_q.adv, ctrl_q.base_sel, 1'b0, ctrl_q.mode, 10'h000};
	wire rd_any = io_rd_i && (sel_ctrl || sel_index || sel_data);
	wire emp_rd_src_t rd_src = sel_ctrl ? EMP_RD_CTRL :
		!prog_ok ? EMP_RD_ZERO :
		sel_index ? EMP_RD_INDEX : EMP_RD_DATA;

	// First read stage waits for the page store's registered output.
	// The hold register loads every cycle; only the copy taken in the
	// request cycle is ever used by the second stage.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_pend_q <= 1'b0;
			rd_src_q <= EMP_RD_ZERO;
			rd_hold_q <= 16'h0000;
		end else begin
			rd_pend_q <= rd_any;
			rd_src_q <= rd_src;
			rd_hold_q <= sel_ctrl ? ctrl_rd : index_rd;
		end
	end

	// Page entry as seen on the data port, bits 14 to 12 reading zero.
	wire [15:0] data_rd = {io_entry.en, 3'h0, io_entry.page};
	wire [15:0] rd_mux = (rd_src_q == EMP_RD_DATA) ? data_rd :
		(rd_src_q == EMP_RD_ZERO) ? 16'h0000 : rd_hold_q;

	// Second read stage drives the port; a read answers two cycles later.
	// Read data holds between answers, so a slow reader may take it late.
	// Writes give no answer at all.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			io_rdata_q <= 16'h0000;
			io_rvalid_q <= 1'b0;
		end else begin
			io_rdata_q <= rd_pend_q ? rd_mux : io_rdata_q;
			io_rvalid_q <= rd_pend_q;
		end
	end

	// Window decode of the processor address, in 16 KB frames.
	// Only the first megabyte holds windows; an access above it passes
	// with no translation, even where its low bits alias a window.
	wire [5:0] frame = cpu_addr_i[19:14];
	wire in_low_mb = (cpu_addr_i[23:20] == 4'h0);
	wire [5:0] upper_first = EMP_UPPER_BASE_FRAME + {4'h0, ctrl_q.base_sel};
	wire [5:0] upper_last = upper_first + EMP_UPPER_SPAN;
	wire hit_upper = in_low_mb && (frame >= upper_first) && (frame <= upper_last);
	wire hit_lower = in_low_mb && (frame >= EMP_LOWER_FIRST_FRAME) &&
		(frame <= EMP_LOWER_LAST_FRAME);

	// The upper base is one frame past a multiple of eight, so the low three
	// frame bits give the register directly and the rotation comes for free.
	wire [5:0] upper_reg = {EMP_UPPER_REG_TOP, frame[2:0]};
	// Frames 32 to 39 wrap onto registers 0 to 7, so the last eight lower
	// windows reuse the first register numbers.
	wire [5:0] lower_reg = (frame >= EMP_LOWER_WRAP_FRAME) ?
		{EMP_LOWER_WRAP_TOP, frame[2:0]} : frame;
	wire [5:0] lookup_reg = hit_upper ? upper_reg : lower_reg;

	// Forty page registers with an I/O read port and a lookup read port.
	// A data port write lands at the next edge, so a lookup in the same
	// cycle still sees the old entry.
	emp_page_mem emp_page_mem_i (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.we_i(page_we),
		.waddr_i(index_q),
		.wdata_i(page_wdata),
		.raddr_a_i(index_q),
		.rdata_a_o(io_entry),
		.raddr_b_i(lookup_reg),
		.rdata_b_o(lk_entry)
	);

	// Lookup stage holds the window kind and offset while the entry is read.
	// The offset loads every cycle; it only matters alongside a hit, and
	// skipping its enable keeps the stage small.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lk_valid_q <= 1'b0;
			lk_upper_q <= 1'b0;
			lk_lower_q <= 1'b0;
			lk_off_q <= '0;
		end else begin
			lk_valid_q <= cpu_valid_i;
			lk_upper_q <= cpu_valid_i && hit_upper;
			lk_lower_q <= cpu_valid_i && hit_lower;
			lk_off_q <= cpu_addr_i[EMP_OFFSET_W-1:0];
		end
	end

	// Effective enable: per register above, as one group below.
	// The stored enable bit is ignored below, and the mode is taken one
	// cycle late, in step with the entry that the store returns.
	wire upper_on = lk_upper_q && ctrl_q.mode[1] && lk_entry.en;
	wire lower_on = lk_lower_q && (ctrl_q.mode == EMP_MAP_ALL);
	wire win_on = upper_on || lower_on;

	// Translation; software keeps enable clear for card pages, so a card
	// page normally arrives here only through a lower window in mode 11.
	always_comb begin
		map_d = EMP_MAP_RST;
		if (win_on && page_onboard(lk_entry.page)) begin
			map_d.onboard = 1'b1;
			map_d.addr = {lk_entry.page[10:0], lk_off_q};
		end else if (win_on && page_external(lk_entry.page)) begin
			map_d.ext_cs = 1'b1;
			map_d.ext_page = lk_entry.page[7:0];
		end
	end

	// Result stage; every result is valid two cycles after the access.
	// Every field clears when nothing hits, so a stale address never
	// follows a refused access onto the memory side.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			map_q <= EMP_MAP_RST;
			map_valid_q <= 1'b0;
		end else begin
			map_q <= map_d;
			map_valid_q <= lk_valid_q;
		end
	end

	// Outputs, each straight from a flip-flop.
	// The card select also enables the shared bus driver, because the bus
	// carries a page only during card cycles.
	assign io_rdata_o = io_rdata_q;
	assign io_rvalid_o = io_rvalid_q;
	assign map_valid_o = map_valid_q;
	assign map_onboard_o = map_q.onboard;
	assign map_addr_o = map_q.addr;
	assign ems_cs_o = map_q.ext_cs;
	assign shared_peripheral_bus_o = map_q.ext_page;
	assign shared_peripheral_bus_oe_o = map_q.ext_cs;

endmodule

/* File: dv/emp_mapper_sva.sv */
/*
 * Checker for the expanded-memory page mapper, bound to its top module.
 * Assumes the two-cycle answer latency of both the I/O port and the lookup.
 */
module emp_mapper_sva
	import emp_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic arst_n_i,
	// I/O port access.
	input wire logic [15:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [15:0] io_wdata_i,
	input wire logic [15:0] io_rdata_o,
	input wire logic io_rvalid_o,
	// Delay-line observation.
	input wire logic delay_test_trigger_i,
	input wire logic [emp_pkg::EMP_OBSERVE_W-1:0] delay_line_observe_i,
	// Processor lookup and result.
	input wire logic cpu_valid_i,
	input wire logic [23:0] cpu_addr_i,
	input wire logic map_valid_o,
	input wire logic map_onboard_o,
	input wire logic [24:0] map_addr_o,
	input wire logic ems_cs_o,
	input wire logic [7:0] shared_peripheral_bus_o,
	input wire logic shared_peripheral_bus_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hit;
	logic [13:0] cpu_off;

	// Port decode and window offset, kept as wires so $past sees plain signals.
	assign hit = io_addr_i inside {EMP_PORT_CTRL, EMP_PORT_INDEX, EMP_PORT_DATA};
	assign cpu_off = cpu_addr_i[13:0];

	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	a_read_answer: assert property (io_rd_i && hit |-> ##2 io_rvalid_o)
		else $error("read of a mapper port got no answer");
	a_answer_cause: assert property (io_rvalid_o |-> $past(io_rd_i, 2) && $past(hit, 2))
		else $error("read answer without a read");
	a_index_high: assert property (io_rvalid_o && $past(io_addr_i, 2) == EMP_PORT_INDEX
		&& !$past(delay_test_trigger_i, 2) |-> io_rdata_o[15:6] == 10'h000)
		else $error("index upper bits not zero");
	a_page_pad: assert property (io_rvalid_o && $past(io_addr_i, 2) == EMP_PORT_DATA
		|-> io_rdata_o[14:12] == 3'h0)
		else $error("page bits 14 to 12 not zero");
	a_lookup_answer: assert property (cpu_valid_i |-> ##2 map_valid_o)
		else $error("lookup got no result");
	a_offset_kept: assert property (map_valid_o && map_onboard_o
		|-> map_addr_o[13:0] == $past(cpu_off, 2))
		else $error("window offset not carried");
	a_high_no_map: assert property (cpu_valid_i && cpu_addr_i[23:20] != 4'h0
		|-> ##2 !map_onboard_o && !ems_cs_o)
		else $error("access above 1 MB translated");
	a_window_gap: assert property (cpu_valid_i && cpu_addr_i[23:17] == 7'h00
		|-> ##2 !map_onboard_o && !ems_cs_o)
		else $error("access below lower windows translated");
	a_card_select: assert property (ems_cs_o |-> shared_peripheral_bus_oe_o && !map_onboard_o)
		else $error("card select without bus drive");
	a_bus_owner: assert property (shared_peripheral_bus_oe_o |-> ems_cs_o)
		else $error("shared bus driven without card select");

	c_card: cover property (map_valid_o && ems_cs_o);
	c_onboard: cover property (map_valid_o && map_onboard_o);
	c_observe: cover property (io_rvalid_o && delay_test_trigger_i);
endmodule

bind emp_mapper emp_mapper_sva emp_mapper_sva_i (.*);

/* File: dv/emp_card_model.sv */
/*
 * Expansion memory card model: latches the page put on the shared bus.
 * Assumes the mapper holds the page while its card select is high.
 */
module emp_card_model (
	// Clock.
	input wire logic clk_i,
	// Card select and page bus.
	input wire logic cs_i,
	input wire logic oe_i,
	input wire logic [7:0] page_i,
	// Page the card would decode.
	output logic [7:0] page_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Only a driven, selected bus is taken, so a stale page is never seen.
	always_ff @(posedge clk_i) begin
		if (cs_i && oe_i) begin
			page_o <= page_i;
		end
	end
endmodule

/* File: dv/emp_mapper_bench.sv */
/*
 * Self-checking bench for the expanded-memory page mapper.
 * Assumes the checker is bound in and the card model sits on the shared bus.
 */
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module emp_mapper_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import emp_pkg::*;
	logic clk_i = 0, arst_n_i = 0, io_rd_i = 0, io_wr_i = 0, cpu_valid_i = 0;
	logic delay_test_trigger_i = 0, io_rvalid_o, map_valid_o, map_onboard_o;
	logic ems_cs_o, shared_peripheral_bus_oe_o;
	logic [15:0] io_addr_i = 0, io_wdata_i = 0, io_rdata_o;
	logic [9:0] delay_line_observe_i = 0;
	logic [23:0] cpu_addr_i = 0;
	logic [24:0] map_addr_o;
	logic [7:0] shared_peripheral_bus_o, card_page;
	int fail_count = 0, n_tests = 0, cyc = 0;

	emp_mapper emp_mapper_i (.*);
	emp_card_model emp_card_model_i (.clk_i(clk_i), .cs_i(ems_cs_o),
		.oe_i(shared_peripheral_bus_oe_o), .page_i(shared_peripheral_bus_o), .page_o(card_page));

	// 20 MHz clock; the ceiling is far above the few hundred cycles needed.
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One strobe cycle then one idle cycle, so strobes never change twice at once.
	task automatic io(input logic w, input logic [15:0] a, input logic [15:0] d);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = w;
		io_rd_i = !w;
		@(posedge clk_i);
		#5;
		io_wr_i = 0;
		io_rd_i = 0;
		@(posedge clk_i);
		#5;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		io(1'b0, a, 16'h0000);
		for (int k = 0; k < 4 && io_rvalid_o !== 1'b1; k++) begin
			@(posedge clk_i);
			#5;
		end
		`CHK(io_rvalid_o, 1'b1)
		`CHK(io_rdata_o, e)
	endtask

	// A zero address means no on-board hit, a zero page means no card cycle.
	task automatic lk(input logic [23:0] a, input logic [24:0] ma, input logic [7:0] pg);
		cpu_addr_i = a;
		cpu_valid_i = 1;
		@(posedge clk_i);
		#5;
		cpu_valid_i = 0;
		for (int k = 0; k < 4 && map_valid_o !== 1'b1; k++) begin
			@(posedge clk_i);
			#5;
		end
		`CHK(map_valid_o, 1'b1)
		`CHK(map_onboard_o, ma != 25'h0)
		`CHK(map_addr_o, ma)
		`CHK(ems_cs_o, pg != 8'h00)
		`CHK(shared_peripheral_bus_o, pg)
		@(posedge clk_i);
		#5;
	endtask

	// Main sequence: reset state, index field, programming, windows and modes.
	initial begin
		repeat (12) @(posedge clk_i);
		#5;
		arst_n_i = 1;
		rd(EMP_PORT_CTRL, 16'h0000);
		io(1'b1, EMP_PORT_CTRL, 16'h8400);
		rd(EMP_PORT_INDEX, 16'h0000);
		io(1'b1, EMP_PORT_INDEX, 16'h0020);
		for (int i = 0; i < 8; i++) rd(EMP_PORT_DATA, 16'h0000);
		rd(EMP_PORT_INDEX, 16'h0028);
		io(1'b1, EMP_PORT_INDEX, 16'hffff);
		rd(EMP_PORT_INDEX, 16'h003f);
		delay_test_trigger_i = 1;
		delay_line_observe_i = 10'h2a5;
		rd(EMP_PORT_INDEX, {10'h2a5, 6'h3f});
		delay_test_trigger_i = 0;
		$display("test reset and index done");
		io(1'b1, EMP_PORT_INDEX, 16'h0020);
		for (int i = 0; i < 8; i++) io(1'b1, EMP_PORT_DATA, 16'((i != 7) * 32'h8000 + 32'h7040 + i));
		io(1'b1, EMP_PORT_INDEX, 16'h0020);
		for (int i = 0; i < 8; i++) rd(EMP_PORT_DATA, 16'((i != 7) * 32'h8000 + 32'h40 + i));
		io(1'b1, EMP_PORT_CTRL, 16'h0400);
		io(1'b1, EMP_PORT_INDEX, 16'h0000);
		io(1'b1, EMP_PORT_DATA, 16'h0805);
		io(1'b1, EMP_PORT_INDEX, 16'h0008);
		io(1'b1, EMP_PORT_DATA, 16'h0008);
		rd(EMP_PORT_INDEX, 16'h0008);
		io(1'b1, EMP_PORT_INDEX, 16'h0009);
		io(1'b1, EMP_PORT_DATA, 16'h0030);
		$display("test programming done");
		for (int b = 0; b < 4; b++) begin
			io(1'b1, EMP_PORT_CTRL, 16'(b * 32'h2000 + 32'h0800));
			lk(24'(32'hc4123 + b * 32'h4000), 25'((32'h41 + b) * 32'h4000 + 32'h123), 8'h00);
			lk(24'(32'hc0123 + b * 32'h4000), 25'h0, 8'h00);
			lk(24'(32'he0000 + b * 32'h4000), 25'((32'h40 + b) * 32'h4000), 8'h00);
			lk(24'h0dc010, 25'h0, 8'h00);
		end
		$display("test upper windows done");
		lk(24'h020123, 25'h0, 8'h00);
		io(1'b1, EMP_PORT_CTRL, 16'h0c00);
		rd(EMP_PORT_CTRL, 16'h0c00);
		lk(24'h020123, 25'h020123, 8'h00);
		lk(24'h024000, 25'h0, 8'h00);
		lk(24'h080010, 25'h0, 8'h05);
		`CHK(card_page, 8'h05)
		lk(24'h010123, 25'h0, 8'h00);
		lk(24'h1c4123, 25'h0, 8'h00);
		io(1'b1, EMP_PORT_INDEX, 16'h0001);
		io(1'b1, EMP_PORT_DATA, 16'h0900);
		io(1'b1, EMP_PORT_INDEX, 16'h0007);
		io(1'b1, EMP_PORT_DATA, 16'h0003);
		lk(24'h084010, 25'h0, 8'h00);
		lk(24'h09c010, 25'h00c010, 8'h00);
		lk(24'h0a0010, 25'h0, 8'h00);
		io(1'b1, EMP_PORT_CTRL, 16'h0400);
		lk(24'h0c4123, 25'h0, 8'h00);
		io(1'b1, EMP_PORT_CTRL, 16'h0000);
		lk(24'h0c4123, 25'h0, 8'h00);
		io(1'b1, EMP_PORT_INDEX, 16'h0011);
		rd(EMP_PORT_INDEX, 16'h0000);
		io(1'b1, EMP_PORT_CTRL, 16'h0400);
		rd(EMP_PORT_INDEX, 16'h0007);
		$display("test lower windows and modes done");
		end_sim();
	end
endmodule
